// ---- common/rotate_pkg.sv ----
// constants, field layout and phase encoding for the right-rotate datapath
package rotate_pkg;

    // ------------------------------------------------------------
    // instruction word layout
    // ------------------------------------------------------------
    localparam int OPCODE_MSB = 15;
    localparam int OPCODE_LSB = 10;
    localparam int DEST_BIT   = 9;
    localparam int BANK_BIT   = 8;
    localparam int ADDR_MSB   = 7;
    localparam int ADDR_LSB   = 0;

    localparam logic [5:0] OPC_ROTATE_CARRY    = 6'h0C;
    localparam logic [5:0] OPC_ROTATE_NO_CARRY = 6'h10;

    // ------------------------------------------------------------
    // data address formation
    // ------------------------------------------------------------
    localparam int DATA_W      = 8;
    localparam int BANK_W      = 4;
    localparam int DATA_ADDR_W = 12;
    localparam int MEM_DEPTH   = 4096;

    localparam logic [7:0] INDEXED_LIMIT    = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT     = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  WORKING_RESET = 8'h00;
    localparam logic        FLAG_RESET    = 1'b0;
    localparam logic [15:0] INSTR_RESET   = 16'h0000;
    localparam logic [11:0] ADDR_RESET    = 12'h000;

    // ------------------------------------------------------------
    // instruction cycle phases
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE    = 3'b000,
        PH_DECODE  = 3'b001,
        PH_READ    = 3'b010,
        PH_PROCESS = 3'b011,
        PH_WRITE   = 3'b100
    } phase_t;

endpackage

// ---- rtl/file_register_ram.sv ----
// byte-wide file register memory with registered read data
`timescale 1ns/1ps
module file_register_ram (
    input  wire logic                                clk_in,
    input  wire logic                                wr_en_in,
    input  wire logic [rotate_pkg::DATA_ADDR_W-1:0]  addr_in,
    input  wire logic [rotate_pkg::DATA_W-1:0]       wr_data_in,
    output logic      [rotate_pkg::DATA_W-1:0]       rd_data_out
);

    logic [rotate_pkg::DATA_W-1:0] mem [rotate_pkg::MEM_DEPTH];

    // read-before-write: a same-cycle write shows on the next read
    always_ff @(posedge clk_in) begin
        rd_data_out <= mem[addr_in];
    end

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[addr_in] <= wr_data_in;
        end
    end

endmodule

// ---- rtl/rotate_right_instructions.sv ----
// right-rotate instruction execution: decode, read, process, write back
`timescale 1ns/1ps
//
// Notes on behaviour
// - through-carry rotate: bit 0 to carry, old carry to bit 7, carry, negative, zero update.
// - through-carry decode: 16-bit word, opcode, dest and bank bits, 8-bit address low.
// - no-carry rotate: bit 0 wraps to bit 7, carry kept, negative and zero update.
// - destination 0 writes the working register, 1 writes back to the file register.
// - bank bit 0 addresses the quick-access bank and ignores the bank select register.
// - bank bit 1 forms the address from the bank select register and the 8-bit field.
// - extended set on, bank bit 0 and address up to 95: indexed literal offset addressing.
//
module rotate_right_instructions (
    input  wire logic                                clk_in,
    input  wire logic                                rst_in,
    input  wire logic [15:0]                         instr_in,
    input  wire logic                                instr_valid_in,
    output logic                                     instr_ready_out,
    input  wire logic                                extended_set_in,
    input  wire logic [rotate_pkg::BANK_W-1:0]       bank_select_register_in,
    input  wire logic [rotate_pkg::DATA_ADDR_W-1:0]  index_base_in,
    input  wire logic                                host_wr_en_in,
    input  wire logic [rotate_pkg::DATA_ADDR_W-1:0]  host_addr_in,
    input  wire logic [rotate_pkg::DATA_W-1:0]       host_wr_data_in,
    output logic      [rotate_pkg::DATA_W-1:0]       host_rd_data_out,
    input  wire logic                                working_load_in,
    input  wire logic [rotate_pkg::DATA_W-1:0]       working_load_data_in,
    input  wire logic                                carry_load_in,
    input  wire logic                                carry_load_data_in,
    output logic      [rotate_pkg::DATA_W-1:0]       working_reg_out,
    output logic                                     carry_out,
    output logic                                     negative_out,
    output logic                                     zero_out,
    output logic                                     done_out,
    output logic                                     illegal_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rotate_pkg::phase_t                     phase;
    logic [15:0]                            instr;
    logic                                   ext_set;
    logic [rotate_pkg::BANK_W-1:0]          bank_sel;
    logic [rotate_pkg::DATA_ADDR_W-1:0]     index_base;
    logic [rotate_pkg::DATA_ADDR_W-1:0]     eff_addr;
    logic [rotate_pkg::DATA_W-1:0]          source;
    logic [rotate_pkg::DATA_W-1:0]          result;
    logic                                   op_carry;
    logic                                   dest_file;
    logic [rotate_pkg::DATA_W-1:0]          mem_rd_data;
    logic [rotate_pkg::DATA_ADDR_W-1:0]     mem_addr;
    logic                                   mem_wr_en;
    logic [rotate_pkg::DATA_W-1:0]          mem_wr_data;
    logic                                   taken;
    logic [5:0]                             opcode;
    logic [7:0]                             f_field;
    logic                                   bank_bit;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_rotate(input logic [15:0] word);
        logic [5:0] opc;
        opc = word[rotate_pkg::OPCODE_MSB:rotate_pkg::OPCODE_LSB];
        return (opc == rotate_pkg::OPC_ROTATE_CARRY) || (opc == rotate_pkg::OPC_ROTATE_NO_CARRY);
    endfunction

    function automatic logic [7:0] rotate_right(input logic [7:0] val, input logic fill);
        return {fill, val[7:1]};
    endfunction

    function automatic logic indexed_mode(input logic ext, input logic a, input logic [7:0] f);
        return ext && !a && (f <= rotate_pkg::INDEXED_LIMIT);
    endfunction

    assign opcode          = instr[rotate_pkg::OPCODE_MSB:rotate_pkg::OPCODE_LSB];
    assign f_field         = instr[rotate_pkg::ADDR_MSB:rotate_pkg::ADDR_LSB];
    assign bank_bit        = instr[rotate_pkg::BANK_BIT];
    assign instr_ready_out = (phase == rotate_pkg::PH_IDLE);
    assign taken           = instr_valid_in && instr_ready_out;

    // ------------------------------------------------------------
    // phase sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            phase <= rotate_pkg::PH_IDLE;
        end else begin
            unique case (phase)
                rotate_pkg::PH_IDLE: begin
                    if (taken) begin
                        phase <= rotate_pkg::PH_DECODE;
                    end
                end
                rotate_pkg::PH_DECODE: begin
                    phase <= is_rotate(instr) ? rotate_pkg::PH_READ
                                              : rotate_pkg::PH_IDLE;
                end
                rotate_pkg::PH_READ:    phase <= rotate_pkg::PH_PROCESS;
                rotate_pkg::PH_PROCESS: phase <= rotate_pkg::PH_WRITE;
                rotate_pkg::PH_WRITE:   phase <= rotate_pkg::PH_IDLE;
                default:                phase <= rotate_pkg::PH_IDLE;
            endcase
        end
    end

    // operand context is frozen at take so mid-cycle port changes don't leak in
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            instr      <= rotate_pkg::INSTR_RESET;
            ext_set    <= 1'b0;
            bank_sel   <= '0;
            index_base <= rotate_pkg::ADDR_RESET;
        end else if (taken) begin
            instr      <= instr_in;
            ext_set    <= extended_set_in;
            bank_sel   <= bank_select_register_in;
            index_base <= index_base_in;
        end
    end

    // ------------------------------------------------------------
    // decode: operation, destination, effective address
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            op_carry  <= 1'b0;
            dest_file <= 1'b0;
            eff_addr  <= rotate_pkg::ADDR_RESET;
        end else if (phase == rotate_pkg::PH_DECODE) begin
            op_carry  <= (opcode == rotate_pkg::OPC_ROTATE_CARRY);
            dest_file <= instr[rotate_pkg::DEST_BIT];
            if (indexed_mode(ext_set, bank_bit, f_field)) begin
                eff_addr <= index_base + {4'h0, f_field};
            end else if (bank_bit) begin
                eff_addr <= {bank_sel, f_field};
            end else if (f_field < rotate_pkg::ACCESS_SPLIT) begin
                eff_addr <= {rotate_pkg::ACCESS_LOW_BANK, f_field};
            end else begin
                eff_addr <= {rotate_pkg::ACCESS_HIGH_BANK, f_field};
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            illegal_out <= 1'b0;
        end else begin
            illegal_out <= (phase == rotate_pkg::PH_DECODE) && !is_rotate(instr);
        end
    end

    // ------------------------------------------------------------
    // memory port: core owns it while busy, host otherwise
    // ------------------------------------------------------------
    assign mem_addr    = instr_ready_out ? host_addr_in : eff_addr;
    assign mem_wr_en   = instr_ready_out ? host_wr_en_in
                                         : ((phase == rotate_pkg::PH_WRITE) && dest_file);
    assign mem_wr_data = instr_ready_out ? host_wr_data_in : result;
    assign host_rd_data_out = mem_rd_data;

    file_register_ram u_ram (
        .clk_in      (clk_in),
        .wr_en_in    (mem_wr_en),
        .addr_in     (mem_addr),
        .wr_data_in  (mem_wr_data),
        .rd_data_out (mem_rd_data)
    );

    // ------------------------------------------------------------
    // process: rotate the byte read in the read phase
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            source <= '0;
            result <= '0;
        end else if (phase == rotate_pkg::PH_PROCESS) begin
            source <= mem_rd_data;
            if (op_carry) begin
                result <= rotate_right(mem_rd_data, carry_out);
            end else begin
                result <= rotate_right(mem_rd_data, mem_rd_data[0]);
            end
        end
    end

    // ------------------------------------------------------------
    // write: working register and status flags
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            working_reg_out <= rotate_pkg::WORKING_RESET;
        end else if ((phase == rotate_pkg::PH_WRITE) && !dest_file) begin
            working_reg_out <= result;
        end else if (instr_ready_out && working_load_in) begin
            working_reg_out <= working_load_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            carry_out    <= rotate_pkg::FLAG_RESET;
            negative_out <= rotate_pkg::FLAG_RESET;
            zero_out     <= rotate_pkg::FLAG_RESET;
        end else if (phase == rotate_pkg::PH_WRITE) begin
            if (op_carry) begin
                carry_out <= source[0];
            end
            negative_out <= result[7];
            zero_out     <= (result == '0);
        end else if (instr_ready_out && carry_load_in) begin
            carry_out <= carry_load_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            done_out <= 1'b0;
        end else begin
            done_out <= (phase == rotate_pkg::PH_WRITE);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_carry_rotate_value: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (phase == rotate_pkg::PH_PROCESS && op_carry)
            |=> (result == {$past(carry_out), $past(mem_rd_data[7:1])})
    ) else $error("through-carry rotate result wrong");

    chk_carry_flag_update: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (phase == rotate_pkg::PH_WRITE && op_carry) |=> (carry_out == $past(source[0]))
    ) else $error("carry not taken from source bit 0");

    chk_rotate_decode: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (taken && instr_in[15:10] == rotate_pkg::OPC_ROTATE_CARRY)
            |=> ##1 (op_carry && dest_file == $past(instr_in[9], 2))
    ) else $error("through-carry opcode not decoded");

    chk_plain_rotate_keep: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (phase == rotate_pkg::PH_PROCESS && !op_carry)
            |=> (result == {$past(mem_rd_data[0]), $past(mem_rd_data[7:1])})
                ##1 ($stable(carry_out) && zero_out == ($past(result) == 8'h00))
    ) else $error("no-carry rotate wrong or carry disturbed");

    chk_dest_select: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (phase == rotate_pkg::PH_WRITE)
            |-> (mem_wr_en == dest_file)
                ##1 (dest_file || working_reg_out == $past(result))
    ) else $error("destination select wrong");

    chk_access_bank: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (phase == rotate_pkg::PH_READ && !bank_bit && !indexed_mode(ext_set, 1'b0, f_field))
            |-> (eff_addr[11:8] == ((f_field < rotate_pkg::ACCESS_SPLIT)
                 ? rotate_pkg::ACCESS_LOW_BANK : rotate_pkg::ACCESS_HIGH_BANK))
    ) else $error("access bank address wrong");

    chk_banked_address: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (phase == rotate_pkg::PH_READ && bank_bit) |-> (mem_addr == {bank_sel, f_field})
    ) else $error("banked address wrong");

    chk_indexed_address: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (phase == rotate_pkg::PH_READ && indexed_mode(ext_set, bank_bit, f_field))
            |-> (eff_addr == index_base + {4'h0, f_field})
    ) else $error("indexed literal offset address wrong");

    chk_cycle_length: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (taken && is_rotate(instr_in)) |=> !done_out [*4] ##1 done_out
    ) else $error("rotate did not finish in four phases");

endmodule

// ---- verif/rotate_right_instructions_tb.sv ----
// self-checking testbench for the right-rotate instruction datapath
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end
module rotate_right_instructions_tb;
    logic        clk_in;
    logic        rst_in;
    logic [15:0] instr_in;
    logic        instr_valid_in;
    logic        instr_ready_out;
    logic        extended_set_in;
    logic [3:0]  bank_select_register_in;
    logic [11:0] index_base_in;
    logic        host_wr_en_in;
    logic [11:0] host_addr_in;
    logic [7:0]  host_wr_data_in;
    logic [7:0]  host_rd_data_out;
    logic        working_load_in;
    logic [7:0]  working_load_data_in;
    logic        carry_load_in;
    logic        carry_load_data_in;
    logic [7:0]  working_reg_out;
    logic        carry_out;
    logic        negative_out;
    logic        zero_out;
    logic        done_out;
    logic        illegal_out;
    int          n_errors;
    int          total_checks;
    logic [31:0] seed;

    rotate_right_instructions dut (
        .clk_in(clk_in), .rst_in(rst_in), .instr_in(instr_in),
        .instr_valid_in(instr_valid_in), .instr_ready_out(instr_ready_out),
        .extended_set_in(extended_set_in), .bank_select_register_in(bank_select_register_in),
        .index_base_in(index_base_in), .host_wr_en_in(host_wr_en_in),
        .host_addr_in(host_addr_in), .host_wr_data_in(host_wr_data_in),
        .host_rd_data_out(host_rd_data_out), .working_load_in(working_load_in),
        .working_load_data_in(working_load_data_in), .carry_load_in(carry_load_in),
        .carry_load_data_in(carry_load_data_in), .working_reg_out(working_reg_out),
        .carry_out(carry_out), .negative_out(negative_out), .zero_out(zero_out),
        .done_out(done_out), .illegal_out(illegal_out)
    );

    // ------------------------------------------------------------
    // clock, stimulus helpers
    // ------------------------------------------------------------
    always #5 clk_in = ~clk_in;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // effective data address, order of precedence matters: indexed beats access bank
    function automatic logic [11:0] eff_addr(input logic a, input logic [7:0] f,
                                             input logic [3:0] bank_select_register, input logic ext,
                                             input logic [11:0] idx);
        if (ext && !a && f <= rotate_pkg::INDEXED_LIMIT) return idx + {4'h0, f};
        if (a) return {bank_select_register, f};
        if (f < rotate_pkg::ACCESS_SPLIT) return {rotate_pkg::ACCESS_LOW_BANK, f};
        return {rotate_pkg::ACCESS_HIGH_BANK, f};
    endfunction

    // expected rotate result straight from the operation definitions
    function automatic logic [7:0] rot_expect(input logic carry_op, input logic [7:0] src,
                                              input logic c0);
        return carry_op ? {c0, src[7:1]} : {src[0], src[7:1]};
    endfunction

    task automatic end_sim;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // one rotate: preload, issue, check flags, W and memory
    // ------------------------------------------------------------
    task automatic run_rot(input logic [5:0] opc, input logic d, input logic a,
                           input logic [7:0] f, input logic [3:0] bank_select_register, input logic ext,
                           input logic [11:0] idx, input logic [7:0] src,
                           input logic [7:0] w0, input logic c0);
        logic [11:0] ea;
        logic [7:0]  res;
        ea = eff_addr(a, f, bank_select_register, ext, idx);
        res = rot_expect(opc == rotate_pkg::OPC_ROTATE_CARRY, src, c0);
        @(posedge clk_in);
        host_wr_en_in <= 1'b1;
        host_addr_in <= ea;
        host_wr_data_in <= src;
        working_load_in <= 1'b1;
        working_load_data_in <= w0;
        carry_load_in <= 1'b1;
        carry_load_data_in <= c0;
        @(posedge clk_in);
        host_wr_en_in <= 1'b0;
        working_load_in <= 1'b0;
        carry_load_in <= 1'b0;
        instr_in <= {opc, d, a, f};
        instr_valid_in <= 1'b1;
        extended_set_in <= ext;
        bank_select_register_in <= bank_select_register;
        index_base_in <= idx;
        @(posedge clk_in);
        instr_valid_in <= 1'b0;
        // junk host traffic while busy must not land
        host_wr_en_in <= 1'b1;
        host_wr_data_in <= ~src;
        #1 `CHK(instr_ready_out, 1'b0)
        repeat (3) @(posedge clk_in);
        host_wr_en_in <= 1'b0;
        #1 `CHK(done_out, 1'b0)
        @(posedge clk_in);
        #1 `CHK(done_out, 1'b1)
        if (opc == rotate_pkg::OPC_ROTATE_CARRY) begin
            `CHK(carry_out, src[0])
        end else begin
            `CHK(carry_out, c0)
        end
        `CHK(negative_out, res[7])
        `CHK(zero_out, res == 8'h00)
        `CHK(working_reg_out, d ? w0 : res)
        @(posedge clk_in);
        host_addr_in <= ea;
        repeat (2) @(posedge clk_in);
        #1 `CHK(host_rd_data_out, d ? res : src)
    endtask

    task automatic run_illegal(input logic [5:0] opc);
        @(posedge clk_in);
        instr_in <= {opc, 10'h3A5};
        instr_valid_in <= 1'b1;
        @(posedge clk_in);
        instr_valid_in <= 1'b0;
        @(posedge clk_in);
        #1 `CHK(illegal_out, 1'b1)
        `CHK(done_out, 1'b0)
        `CHK(instr_ready_out, 1'b1)
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_in);
        n_errors++;
        end_sim();
    end

    initial begin
        logic [5:0] bad_ops [4];
        clk_in = 1'b0;
        rst_in = 1'b1;
        instr_in = 16'h0000;
        instr_valid_in = 1'b0;
        extended_set_in = 1'b0;
        bank_select_register_in = 4'h0;
        index_base_in = 12'h000;
        host_wr_en_in = 1'b0;
        host_addr_in = 12'h000;
        host_wr_data_in = 8'h00;
        working_load_in = 1'b0;
        working_load_data_in = 8'h00;
        carry_load_in = 1'b0;
        carry_load_data_in = 1'b0;
        n_errors = 0;
        total_checks = 0;
        seed = 32'h5E2C9033;
        bad_ops = '{6'h00, 6'h3F, 6'h0D, 6'h11};
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        #1 `CHK(working_reg_out, 8'h00)
        `CHK({carry_out, negative_out, zero_out, done_out}, 4'h0)
        `CHK(instr_ready_out, 1'b1)
        // corners: zero result, indexed edge 0x5F, split 0x60, bank select, top of access bank
        run_rot(rotate_pkg::OPC_ROTATE_CARRY, 1'b0, 1'b0, 8'h10,
                4'h3, 1'b0, 12'h000, 8'h01, 8'h55, 1'b0);
        run_rot(rotate_pkg::OPC_ROTATE_NO_CARRY, 1'b1, 1'b0, 8'h5F,
                4'h7, 1'b1, 12'hFF0, 8'hD7, 8'h11, 1'b1);
        run_rot(rotate_pkg::OPC_ROTATE_CARRY, 1'b1, 1'b0, 8'h60,
                4'h7, 1'b1, 12'h200, 8'hE6, 8'h22, 1'b1);
        run_rot(rotate_pkg::OPC_ROTATE_NO_CARRY, 1'b0, 1'b1, 8'h5F,
                4'hA, 1'b1, 12'h300, 8'h80, 8'h33, 1'b0);
        run_rot(rotate_pkg::OPC_ROTATE_CARRY, 1'b1, 1'b0, 8'hFF,
                4'h2, 1'b0, 12'h000, 8'h00, 8'h44, 1'b1);
        for (int i = 0; i < 150; i++) begin
            seed = lfsr_next(seed);
            run_rot(seed[0] ? rotate_pkg::OPC_ROTATE_CARRY : rotate_pkg::OPC_ROTATE_NO_CARRY,
                    seed[1], seed[2], seed[10:3], seed[14:11], seed[15], seed[27:16],
                    seed[31:24] ^ seed[7:0], seed[23:16], seed[28]);
        end
        foreach (bad_ops[k]) begin
            run_illegal(bad_ops[k]);
        end
        end_sim();
    end
endmodule
